// file: src/tcp_regs.sv
`timescale 1ns/1ns
// Overview of operation
// - Answer on the two-wire bus at seven-bit address 0100010, bit 0 direction.
// - Byte port 0x43 pushes writes to transmit, pops receive, no increment.
// - Main event flags at 0x42 latch eight events, clear on read, reset 00.
// - Secondary event flags at 0x3E latch eight events, clear on read.
// - Register 0x3F bit 0 flags acknowledgement sent, clears on read.
// - Reset register 0x0C: bit 0 full reset, bit 1 protocol reset, self-clearing.
// - Queue status at 0x41 reports queues and faults, resets to 28.
// - Masks at 0x0A, 0x0E, 0x0F align with flags, reset to 00.
// - Register 0x06 holds flush, global mask, host current, preamble, start; reset 24.
// - Register 0x02 holds pull-ups, supply routing, measure select, pull-downs; reset 03.
// - Register 0x03 holds roles, revision, auto acknowledge, transmit line; reset 20.
// - Register 0x09 holds hard reset, auto resets, retry count, retry; reset 06.
// - Registers 0x07 and 0x08 hold packet enables, flush and toggle controls.
// - Power register 0x0B holds four block enables, resets to 01.
// - Register 0x04 resets 31, slicer register 0x05 resets 60.
// - Over-current register 0x0D holds range and limit code, resets 0F.
// - Read-only line status at 0x40 reports line and level state.
// - Read-only status at 0x3C and 0x3D reports protocol and toggle state.
// - Identification 0x01 is read-only: version high nibble, revision low.
module tcp_regs #(
  parameter logic [3:0] VERSION_ID = 4'h5,  // Arbitrary value
  parameter logic [3:0] REVISION_ID = 4'h2  // Arbitrary value
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe,
  input wire logic [7:0] main_event_set,
  input wire logic [7:0] secondary_event_set,
  input wire logic ack_sent_set,
  input wire logic [7:0] line_status_in,
  input wire logic [7:0] queue_status_in,
  input wire logic [7:0] protocol_status_a_in,
  input wire logic [7:0] toggle_sop_status_in,
  input wire logic [7:0] rx_byte,
  output logic rx_pop,
  output logic tx_push,
  output logic [7:0] tx_byte,
  output logic tx_start,
  output logic tx_flush,
  output logic rx_flush,
  output logic full_soft_reset,
  output logic protocol_logic_reset,
  output logic [7:0] cc_switch_control,
  output logic [7:0] role_and_tx_select,
  output logic [7:0] comparator_threshold,
  output logic [7:0] slicer_threshold,
  output logic [7:0] tx_and_host_control,
  output logic [7:0] rx_packet_control,
  output logic [7:0] toggle_control,
  output logic [7:0] retry_reset_control,
  output logic [7:0] main_event_mask,
  output logic [7:0] block_power_enable,
  output logic [7:0] overcurrent_limit,
  output logic [7:0] secondary_event_mask,
  output logic [7:0] ack_sent_mask,
  output logic [7:0] main_event_flags,
  output logic [7:0] secondary_event_flags,
  output logic [7:0] ack_sent_flag
);
  import tcp_pkg::*;

  // ---------------------------------------------------------------
  // Bus engine
  // ---------------------------------------------------------------
  logic wr_pulse, wr_first, rd_req;
  logic [7:0] wr_data;
  logic [7:0] rd_byte;

  tcp_i2c_link u_link (
    .clock(clock),
    .rst_n(rst_n),
    .scl_pin(scl_pin),
    .sda_pin_in(sda_pin_in),
    .sda_pin_oe(sda_pin_oe),
    .wr_pulse(wr_pulse),
    .wr_first(wr_first),
    .wr_data(wr_data),
    .rd_req(rd_req),
    .rd_data(rd_byte)
  );

  // Open-drain pin only ever pulls low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sda_pin_out <= 1'b0;
    end else begin
      sda_pin_out <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Register pointer
  // ---------------------------------------------------------------
  logic [7:0] ptr;
  logic wr_reg, at_port, soft_rst;
  assign wr_reg = wr_pulse && !wr_first;
  assign at_port = (ptr == OFS_BYTE_PORT);
  assign soft_rst = wr_reg && ptr == OFS_RESET && wr_data[BIT_FULL_RST];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptr <= 8'h00;
    end else if (wr_pulse && wr_first) begin
      ptr <= wr_data;
    end else if ((wr_reg || rd_req) && !at_port) begin
      ptr <= ptr + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Writable block
  // ---------------------------------------------------------------
  logic [7:0] cfg [CFG_COUNT];

  for (genvar i = 0; i < CFG_COUNT; i++) begin : g_cfg
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        cfg[i] <= CFG_RST[i];
      end else if (soft_rst) begin
        cfg[i] <= CFG_RST[i];
      end else if (wr_reg && ptr == OFS_CFG_FIRST + 8'(i)) begin
        cfg[i] <= wr_data & CFG_WMASK[i];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cc_switch_control <= CFG_RST[IDX_SW0];
      role_and_tx_select <= CFG_RST[IDX_SW1];
      comparator_threshold <= CFG_RST[IDX_MEAS];
      slicer_threshold <= CFG_RST[IDX_SLICE];
      tx_and_host_control <= CFG_RST[IDX_CTL0];
      rx_packet_control <= CFG_RST[IDX_CTL1];
      toggle_control <= CFG_RST[IDX_CTL2];
      retry_reset_control <= CFG_RST[IDX_CTL3];
      main_event_mask <= CFG_RST[IDX_MAIN_EVENT_MASK];
      block_power_enable <= CFG_RST[IDX_POWER];
      overcurrent_limit <= CFG_RST[IDX_OCP];
      secondary_event_mask <= CFG_RST[IDX_MASKA];
      ack_sent_mask <= CFG_RST[IDX_MASKB];
    end else begin
      cc_switch_control <= cfg[IDX_SW0];
      role_and_tx_select <= cfg[IDX_SW1];
      comparator_threshold <= cfg[IDX_MEAS];
      slicer_threshold <= cfg[IDX_SLICE];
      tx_and_host_control <= cfg[IDX_CTL0];
      rx_packet_control <= cfg[IDX_CTL1];
      toggle_control <= cfg[IDX_CTL2];
      retry_reset_control <= cfg[IDX_CTL3];
      main_event_mask <= cfg[IDX_MAIN_EVENT_MASK];
      block_power_enable <= cfg[IDX_POWER];
      overcurrent_limit <= cfg[IDX_OCP];
      secondary_event_mask <= cfg[IDX_MASKA];
      ack_sent_mask <= cfg[IDX_MASKB];
    end
  end

  // ---------------------------------------------------------------
  // Self-clearing commands
  // ---------------------------------------------------------------
  logic wr_ctl0, wr_ctl1, wr_rst;
  assign wr_ctl0 = wr_reg && ptr == OFS_CFG_FIRST + 8'(IDX_CTL0);
  assign wr_ctl1 = wr_reg && ptr == OFS_CFG_FIRST + 8'(IDX_CTL1);
  assign wr_rst = wr_reg && ptr == OFS_RESET;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_start <= 1'b0;
      tx_flush <= 1'b0;
      rx_flush <= 1'b0;
      full_soft_reset <= 1'b0;
      protocol_logic_reset <= 1'b0;
    end else begin
      tx_start <= wr_ctl0 && wr_data[BIT_TX_START];
      tx_flush <= wr_ctl0 && wr_data[BIT_TX_FLUSH];
      rx_flush <= wr_ctl1 && wr_data[BIT_RX_FLUSH];
      full_soft_reset <= wr_rst && wr_data[BIT_FULL_RST];
      protocol_logic_reset <= wr_rst && wr_data[BIT_PROTO_RST];
    end
  end

  // ---------------------------------------------------------------
  // Byte port
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_push <= 1'b0;
      tx_byte <= 8'h00;
      rx_pop <= 1'b0;
    end else begin
      tx_push <= wr_reg && at_port;
      rx_pop <= rd_req && at_port;
      if (wr_reg && at_port) begin
        tx_byte <= wr_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // Status capture
  // ---------------------------------------------------------------
  logic [7:0] line_status, queue_status, status_a, status_b;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      line_status <= STAT_RST;
      queue_status <= QUEUE_RST;
      status_a <= STAT_RST;
      status_b <= STAT_RST;
    end else begin
      line_status <= line_status_in;
      queue_status <= queue_status_in;
      status_a <= protocol_status_a_in;
      status_b <= toggle_sop_status_in;
    end
  end

  // ---------------------------------------------------------------
  // Event flags, set wins over a clearing read
  // ---------------------------------------------------------------
  logic rd_main, rd_sec, rd_ack;
  assign rd_main = rd_req && ptr == OFS_MAIN_FLAGS;
  assign rd_sec = rd_req && ptr == OFS_SEC_FLAGS;
  assign rd_ack = rd_req && ptr == OFS_ACK_FLAG;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      main_event_flags <= FLAG_RST;
    end else if (rd_main || soft_rst) begin
      main_event_flags <= main_event_set;
    end else begin
      main_event_flags <= main_event_flags | main_event_set;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      secondary_event_flags <= FLAG_RST;
    end else if (rd_sec || soft_rst) begin
      secondary_event_flags <= secondary_event_set;
    end else begin
      secondary_event_flags <= secondary_event_flags | secondary_event_set;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_sent_flag <= FLAG_RST;
    end else if (rd_ack || soft_rst) begin
      ack_sent_flag <= {7'h00, ack_sent_set};
    end else begin
      ack_sent_flag <= {7'h00, ack_sent_flag[0] | ack_sent_set};
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [7:0] read_value;
  always_comb begin
    read_value = 8'h00;
    if (ptr >= OFS_CFG_FIRST && ptr <= OFS_CFG_LAST) begin
      read_value = cfg[4'(ptr - OFS_CFG_FIRST)];
    end else begin
      unique case (ptr)
        OFS_IDENT: read_value = {VERSION_ID, REVISION_ID};
        OFS_STAT_A: read_value = status_a;
        OFS_STAT_B: read_value = status_b;
        OFS_SEC_FLAGS: read_value = secondary_event_flags;
        OFS_ACK_FLAG: read_value = ack_sent_flag;
        OFS_LINE: read_value = line_status;
        OFS_QUEUE: read_value = queue_status;
        OFS_MAIN_FLAGS: read_value = main_event_flags;
        OFS_BYTE_PORT: read_value = rx_byte;
        default: read_value = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_byte <= 8'h00;
    end else if (rd_req) begin
      rd_byte <= read_value;
    end
  end

endmodule : tcp_regs

// file: src/tcp_pkg.sv
package tcp_pkg;

  // ---------------------------------------------------------------
  // Bus address and byte framing
  // ---------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h22;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_IDENT = 8'h01;
  localparam logic [7:0] OFS_CFG_FIRST = 8'h02;
  localparam logic [7:0] OFS_RESET = 8'h0c;
  localparam logic [7:0] OFS_CFG_LAST = 8'h0f;
  localparam logic [7:0] OFS_STAT_A = 8'h3c;
  localparam logic [7:0] OFS_STAT_B = 8'h3d;
  localparam logic [7:0] OFS_SEC_FLAGS = 8'h3e;
  localparam logic [7:0] OFS_ACK_FLAG = 8'h3f;
  localparam logic [7:0] OFS_LINE = 8'h40;
  localparam logic [7:0] OFS_QUEUE = 8'h41;
  localparam logic [7:0] OFS_MAIN_FLAGS = 8'h42;
  localparam logic [7:0] OFS_BYTE_PORT = 8'h43;

  // ---------------------------------------------------------------
  // Writable block 0x02..0x0f: index = offset - 0x02
  // ---------------------------------------------------------------
  localparam int CFG_COUNT = 14;
  localparam int IDX_SW0 = 0;
  localparam int IDX_SW1 = 1;
  localparam int IDX_MEAS = 2;
  localparam int IDX_SLICE = 3;
  localparam int IDX_CTL0 = 4;
  localparam int IDX_CTL1 = 5;
  localparam int IDX_CTL2 = 6;
  localparam int IDX_CTL3 = 7;
  localparam int IDX_MAIN_EVENT_MASK = 8;
  localparam int IDX_POWER = 9;
  localparam int IDX_OCP = 11;
  localparam int IDX_MASKA = 12;
  localparam int IDX_MASKB = 13;

  localparam logic [7:0] CFG_RST [CFG_COUNT] = '{
    8'h03, 8'h20, 8'h31, 8'h60, 8'h24, 8'h00, 8'h02,
    8'h06, 8'h00, 8'h01, 8'h00, 8'h0f, 8'h00, 8'h00};

  // Bits that hold state; blank and self-clearing bits read zero
  localparam logic [7:0] CFG_WMASK [CFG_COUNT] = '{
    8'hff, 8'hf7, 8'h7f, 8'hff, 8'h2e, 8'h73, 8'hef,
    8'h5f, 8'hff, 8'h0f, 8'h00, 8'h0f, 8'hff, 8'h01};

  // ---------------------------------------------------------------
  // Self-clearing command bits
  // ---------------------------------------------------------------
  localparam int BIT_TX_START = 0;
  localparam int BIT_TX_FLUSH = 6;
  localparam int BIT_RX_FLUSH = 2;
  localparam int BIT_FULL_RST = 0;
  localparam int BIT_PROTO_RST = 1;

  // ---------------------------------------------------------------
  // Status reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] QUEUE_RST = 8'h28;
  localparam logic [7:0] FLAG_RST = 8'h00;

  typedef enum logic [2:0] {
    TCP_IDLE, TCP_ADDR, TCP_ADDR_ACK, TCP_RX, TCP_RX_ACK, TCP_TX,
    TCP_TX_ACK
  } tcp_link_state_t;

endpackage : tcp_pkg

// file: src/tcp_i2c_link.sv
`timescale 1ns/1ns
module tcp_i2c_link (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_oe,
  output logic wr_pulse,
  output logic wr_first,
  output logic [7:0] wr_data,
  output logic rd_req,
  input wire logic [7:0] rd_data
);
  import tcp_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_pin;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_pin_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  logic scl_rise, scl_fall, start_seen, stop_seen;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_seen = scl_s && scl_d && sda_d && !sda_s;
  assign stop_seen = scl_s && scl_d && !sda_d && sda_s;

  // ---------------------------------------------------------------
  // Byte engine
  // ---------------------------------------------------------------
  tcp_link_state_t state;
  logic [3:0] count;
  logic [7:0] shift;
  logic [7:0] tx_shift;
  logic dir_read, master_ack;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= TCP_IDLE;
      count <= 4'h0;
      shift <= 8'h00;
      tx_shift <= 8'h00;
      dir_read <= 1'b0;
      master_ack <= 1'b0;
      sda_pin_oe <= 1'b0;
      wr_pulse <= 1'b0;
      wr_first <= 1'b0;
      rd_req <= 1'b0;
    end else begin
      wr_pulse <= 1'b0;
      rd_req <= 1'b0;
      if (start_seen) begin
        state <= TCP_ADDR;
        count <= 4'h0;
        sda_pin_oe <= 1'b0;
      end else if (stop_seen) begin
        state <= TCP_IDLE;
        sda_pin_oe <= 1'b0;
      end else begin
        unique case (state)
          TCP_IDLE: begin
          end
          TCP_ADDR: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_s};
              count <= count + 4'h1;
            end else if (scl_fall && count == BYTE_BITS) begin
              if (shift[7:1] == DEV_ADDR) begin
                state <= TCP_ADDR_ACK;
                sda_pin_oe <= 1'b1;
                dir_read <= shift[0];
                wr_first <= 1'b1;
                rd_req <= shift[0];
              end else begin
                state <= TCP_IDLE;
              end
            end
          end
          TCP_ADDR_ACK: begin
            if (scl_fall) begin
              count <= 4'h0;
              if (dir_read) begin
                state <= TCP_TX;
                tx_shift <= rd_data;
                sda_pin_oe <= !rd_data[7];
              end else begin
                state <= TCP_RX;
                sda_pin_oe <= 1'b0;
              end
            end
          end
          TCP_RX: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_s};
              count <= count + 4'h1;
            end else if (scl_fall && count == BYTE_BITS) begin
              state <= TCP_RX_ACK;
              sda_pin_oe <= 1'b1;
              wr_pulse <= 1'b1;
            end
          end
          TCP_RX_ACK: begin
            wr_first <= 1'b0;
            if (scl_fall) begin
              state <= TCP_RX;
              count <= 4'h0;
              sda_pin_oe <= 1'b0;
            end
          end
          TCP_TX: begin
            if (scl_rise) begin
              count <= count + 4'h1;
            end else if (scl_fall) begin
              if (count == BYTE_BITS) begin
                state <= TCP_TX_ACK;
                sda_pin_oe <= 1'b0;
              end else begin
                tx_shift <= {tx_shift[6:0], 1'b0};
                sda_pin_oe <= !tx_shift[6];
              end
            end
          end
          TCP_TX_ACK: begin
            if (scl_rise) begin
              master_ack <= !sda_s;
              rd_req <= !sda_s;
            end else if (scl_fall) begin
              count <= 4'h0;
              if (master_ack) begin
                state <= TCP_TX;
                tx_shift <= rd_data;
                sda_pin_oe <= !rd_data[7];
              end else begin
                state <= TCP_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_data <= 8'h00;
    end else if (state == TCP_RX && scl_fall && count == BYTE_BITS) begin
      wr_data <= shift;
    end
  end

endmodule : tcp_i2c_link

// file: verif/tcp_regs_chk.sv
`timescale 1ns/1ns
module tcp_regs_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sda_pin_out,
  input wire logic [7:0] main_event_set,
  input wire logic [7:0] main_event_flags,
  input wire logic [7:0] secondary_event_set,
  input wire logic [7:0] secondary_event_flags,
  input wire logic ack_sent_set,
  input wire logic [7:0] ack_sent_flag,
  input wire logic full_soft_reset,
  input wire logic protocol_logic_reset,
  input wire logic tx_flush,
  input wire logic rx_flush,
  input wire logic [7:0] cc_switch_control,
  input wire logic [7:0] block_power_enable,
  input wire logic tx_start,
  input wire logic rx_pop,
  input wire logic tx_push
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sda_low_only_a:
    assert property (sda_pin_out == 1'b0) else $error("data pin high");
  main_flag_set_a:
    assert property (main_event_set != 8'h00 |=> (main_event_flags &
      $past(main_event_set)) == $past(main_event_set)) else $error("main");
  sec_flag_set_a:
    assert property (secondary_event_set != 8'h00 |=> (secondary_event_flags
      & $past(secondary_event_set)) == $past(secondary_event_set))
      else $error("secondary flag");
  ack_flag_set_a:
    assert property (ack_sent_set |=> ack_sent_flag == 8'h01)
      else $error("ack flag");
  soft_reset_a:
    assert property (full_soft_reset |=> ##[0:2] cc_switch_control == 8'h03)
      else $error("soft reset");
  self_clear_a:
    assert property ((tx_flush || rx_flush || protocol_logic_reset) |=>
      !(tx_flush || rx_flush || protocol_logic_reset)) else $error("clear");
  start_pulse_a:
    assert property (tx_start |=> !tx_start) else $error("start pulse");
  pop_push_pulse_a:
    assert property ((rx_pop || tx_push) |=> !(rx_pop || tx_push))
      else $error("pop or push pulse");
  power_bits_a:
    assert property (block_power_enable[7:4] == 4'h0) else $error("power");
  cover property (tx_push);
  cover property (rx_pop);
  cover property (full_soft_reset);
  cover property (protocol_logic_reset);
endmodule : tcp_regs_chk

bind tcp_regs tcp_regs_chk i_chk (.clock, .rst_n, .sda_pin_out,
  .main_event_set, .main_event_flags, .secondary_event_set,
  .secondary_event_flags, .ack_sent_set, .ack_sent_flag, .full_soft_reset,
  .protocol_logic_reset, .tx_flush, .rx_flush,
  .cc_switch_control, .block_power_enable, .tx_start, .rx_pop, .tx_push);

// file: verif/tcp_host.sv
`timescale 1ns/1ns
module tcp_host (
  input wire logic clock,
  input wire logic sda_pin_oe,
  output logic scl_pin,
  output logic sda_line
);
  logic sda_m;
  logic rd_valid;
  logic addr_ack;
  logic [7:0] rd_byte;
  logic [7:0] wq[$];
  // -------------------------------
  // Bus master with pulled-up data
  // -------------------------------
  assign sda_line = sda_m & ~sda_pin_oe;
  initial begin
    scl_pin = 1'b1;
    sda_m = 1'b1;
    rd_valid = 1'b0;
  end
  task automatic sd(input logic v);
    repeat (6) @(posedge clock);
    sda_m <= v;
  endtask : sd
  task automatic sc(input logic v);
    repeat (6) @(posedge clock);
    scl_pin <= v;
  endtask : sc
  task automatic bit_io(input logic v, output logic s);
    sd(v);
    sc(1'b1);
    repeat (3) @(posedge clock);
    s = sda_line;
    sc(1'b0);
  endtask : bit_io
  task automatic byte_io(input logic [7:0] v, input logic a,
                         output logic [7:0] r, output logic s);
    for (int i = 7; i >= 0; i--) bit_io(v[i], r[i]);
    bit_io(a, s);
  endtask : byte_io
  // Data changes only while the bus clock is low, except at start or stop
  task automatic xfer(input logic [6:0] a, input logic [7:0] p,
                      input int nw, input int nr);
    logic [7:0] r;
    logic s;
    sd(1'b1);
    sc(1'b1);
    sd(1'b0);
    sc(1'b0);
    byte_io({a, 1'b0}, 1'b1, r, s);
    addr_ack = !s;
    byte_io(p, 1'b1, r, s);
    repeat (nw) byte_io(wq.pop_front(), 1'b1, r, s);
    if (nr > 0) begin
      sd(1'b1);
      sc(1'b1);
      sd(1'b0);
      sc(1'b0);
      byte_io({a, 1'b1}, 1'b1, r, s);
      for (int i = 1; i <= nr; i++) begin
        byte_io(8'hff, i == nr, r, s);
        rd_byte <= r;
        rd_valid <= 1'b1;
        @(posedge clock);
        rd_valid <= 1'b0;
      end
    end
    sd(1'b0);
    sc(1'b1);
    sd(1'b1);
  endtask : xfer
endmodule : tcp_host

// file: verif/tcp_regs_bench.sv
`timescale 1ns/1ns
module tcp_regs_bench;
  import tcp_pkg::*;
  logic clock, rst_n, scl_pin, sda_pin_in, sda_pin_out, sda_pin_oe;
  logic ack_sent_set, rx_pop, tx_push, tx_start, tx_flush, rx_flush;
  logic full_soft_reset;
  logic [7:0] main_event_set, secondary_event_set, rx_byte, tx_byte, e;
  logic [7:0] line_status_in, queue_status_in, protocol_status_a_in;
  logic [7:0] toggle_sop_status_in, cc_switch_control, block_power_enable;
  logic [7:0] main_event_flags, secondary_event_flags, ack_sent_flag;
  logic [7:0] exp_q[$], tx_q[$], d[CFG_COUNT];
  int fails, cmp_count, cyc;
  int seed = 5236;
  tcp_regs #(.VERSION_ID(4'h7), .REVISION_ID(4'h3)) i_dut (
    .clock, .rst_n, .scl_pin, .sda_pin_in, .sda_pin_out, .sda_pin_oe,
    .main_event_set, .secondary_event_set, .ack_sent_set, .line_status_in,
    .queue_status_in, .protocol_status_a_in, .toggle_sop_status_in, .rx_byte,
    .rx_pop, .tx_push, .tx_byte, .tx_start, .tx_flush, .rx_flush,
    .full_soft_reset, .protocol_logic_reset(), .cc_switch_control,
    .role_and_tx_select(), .comparator_threshold(), .slicer_threshold(),
    .tx_and_host_control(), .rx_packet_control(), .toggle_control(),
    .retry_reset_control(), .main_event_mask(), .block_power_enable,
    .overcurrent_limit(), .secondary_event_mask(), .ack_sent_mask(),
    .main_event_flags, .secondary_event_flags, .ack_sent_flag);
  tcp_host i_host (.clock, .sda_pin_oe, .scl_pin, .sda_line(sda_pin_in));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic final_report();
    if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic exp_rst();
    for (int i = 0; i < CFG_COUNT; i++) exp_q.push_back(CFG_RST[i]);
  endtask : exp_rst
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // --------------------------------------
  // Results compared oldest note first
  // --------------------------------------
  always @(posedge clock) begin
    cyc++;
    if (i_host.rd_valid === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : 8'hxx;
      cmp(i_host.rd_byte, e);
    end
    if (tx_push === 1'b1) begin
      e = tx_q.size() ? tx_q.pop_front() : 8'hxx;
      cmp(tx_byte, e);
    end
    if (rx_pop === 1'b1) rx_byte <= rx_byte + 8'h01;
    if (cyc == 60000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    rst_n = 1'b0;
    {main_event_set, secondary_event_set, ack_sent_set} = 17'h0;
    {line_status_in, queue_status_in, protocol_status_a_in} = 24'h0;
    toggle_sop_status_in = 8'h00;
    rx_byte = 8'h10;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    i_host.wq.push_back(8'hff);
    i_host.xfer(DEV_ADDR, OFS_IDENT, 1, 0);
    cmp({7'h0, i_host.addr_ack}, 8'h01);
    exp_q.push_back(8'h73);
    exp_rst();
    i_host.xfer(DEV_ADDR, OFS_IDENT, 0, CFG_COUNT + 1);
    for (int i = 0; i < CFG_COUNT; i++) begin
      d[i] = (i == 10) ? 8'h00 : 8'($random(seed));
      i_host.wq.push_back(d[i]);
      exp_q.push_back(d[i] & CFG_WMASK[i]);
    end
    i_host.xfer(DEV_ADDR, OFS_CFG_FIRST, CFG_COUNT, 0);
    i_host.wq.push_back(~d[0]);
    i_host.xfer(DEV_ADDR ^ 7'h01, OFS_CFG_FIRST, 1, 0);
    cmp({7'h0, i_host.addr_ack}, 8'h00);
    cmp(cc_switch_control, d[0]);
    i_host.xfer(DEV_ADDR, OFS_CFG_FIRST, 0, CFG_COUNT);
    i_host.wq.push_back(8'h03);
    i_host.xfer(DEV_ADDR, OFS_RESET, 1, 0);
    exp_rst();
    i_host.xfer(DEV_ADDR, OFS_CFG_FIRST, 0, CFG_COUNT);
    for (int i = 0; i < 6; i++) d[i] = 8'($random(seed));
    main_event_set <= d[0];
    secondary_event_set <= d[1];
    ack_sent_set <= 1'b1;
    line_status_in <= d[2];
    queue_status_in <= d[3];
    protocol_status_a_in <= d[4];
    toggle_sop_status_in <= d[5];
    @(posedge clock);
    {main_event_set, secondary_event_set, ack_sent_set} <= 17'h0;
    for (int k = 0; k < 2; k++) begin
      exp_q.push_back(d[4]);
      exp_q.push_back(d[5]);
      exp_q.push_back(k ? 8'h00 : d[1]);
      exp_q.push_back(k ? 8'h00 : 8'h01);
      exp_q.push_back(d[2]);
      exp_q.push_back(d[3]);
      exp_q.push_back(k ? 8'h00 : d[0]);
      i_host.xfer(DEV_ADDR, OFS_STAT_A, 0, 7);
    end
    for (int i = 0; i < 3; i++) begin
      i_host.wq.push_back(d[i]);
      tx_q.push_back(d[i]);
      exp_q.push_back(rx_byte + 8'(i));
    end
    i_host.xfer(DEV_ADDR, OFS_BYTE_PORT, 3, 0);
    i_host.xfer(DEV_ADDR, OFS_BYTE_PORT, 0, 3);
    exp_q.push_back(8'h00);
    i_host.xfer(DEV_ADDR, OFS_RESET, 0, 1);
    repeat (20) @(posedge clock);
    cmp(8'(exp_q.size() + tx_q.size()), 8'h00);
    final_report();
  end
endmodule : tcp_regs_bench
